// File: svr_defs.vh
`ifndef SVR_DEFS_VH
`define SVR_DEFS_VH

// Clock rate of the internal oscillator
`define SVR_CLK_KHZ        50000

// Times in milliseconds, as specified
`define SVR_T_POR_MS       250
`define SVR_T_BOR_MS       200
`define SVR_T_WDT_LONG_MS  1400
`define SVR_T_WDT_MID_MS   600
`define SVR_T_WDT_SHORT_MS 200
`define SVR_T_NVWR_MS      5

// Cycle counts of the times at 50 MHz, sized to the counter width
`define SVR_POR_CYC        27'h0bebc20
`define SVR_BOR_CYC        27'h0989680
`define SVR_WDT_LONG_CYC   27'h42c1d80
`define SVR_WDT_MID_CYC    27'h1c9c380
`define SVR_WDT_SHORT_CYC  27'h0989680
`define SVR_NVWR_CYC       27'h003d090

// Counter width, enough for the longest count
`define SVR_CNT_W          27

// Control byte field positions
`define SVR_BIT_PROT_EN    7
`define SVR_BIT_PERIOD_HI  6
`define SVR_BIT_PERIOD_LO  5

// Watchdog period codes
`define SVR_WDT_LONG       2'b00
`define SVR_WDT_MID        2'b01
`define SVR_WDT_SHORT      2'b10
`define SVR_WDT_OFF        2'b11

// Factory values of the nonvolatile bits {protect, hi, lo}
`define SVR_NV_FACTORY     3'h0

`endif

// File: svr_nvbits.v
`timescale 1ns/1ps
`default_nettype none
`include "svr_defs.vh"

module svr_nvbits #(
    parameter [`SVR_CNT_W-1:0] NVWR_CYC = `SVR_NVWR_CYC
) (
    input  wire       clk_i,
    input  wire       nv_clr_n_i,
    input  wire       wr_start_i,
    input  wire [2:0] wdata_i,
    output reg  [2:0] bits_o,
    output reg        busy_o
);

    reg [`SVR_CNT_W-1:0] wr_cnt;
    reg [2:0]            pend;

    // Cell contents follow only the factory clear, never the power-on reset,
    // so they survive power cycles. A running write finishes unless the factory clear aborts it.
    always @(posedge clk_i or negedge nv_clr_n_i) begin
        if (!nv_clr_n_i) begin
            bits_o <= `SVR_NV_FACTORY;
            busy_o <= 1'b0;
            pend   <= `SVR_NV_FACTORY;
            wr_cnt <= {`SVR_CNT_W{1'b0}};
        end else if (busy_o) begin
            if (wr_cnt == NVWR_CYC - 1'b1) begin
                busy_o <= 1'b0;
                bits_o <= pend;
                wr_cnt <= {`SVR_CNT_W{1'b0}};
            end else begin
                wr_cnt <= wr_cnt + 1'b1;
            end
        end else if (wr_start_i) begin
            busy_o <= 1'b1;
            pend   <= wdata_i;
        end
    end

endmodule // svr_nvbits

`default_nettype wire

// File: svr_supervisor.v
// Contract
// (RULE1) Reset is active whenever the supply comparator reports supply below trip.
// (RULE2) After supply recovers, reset holds until supply stays good 200 ms.
// (RULE3) Reset asserts at power-up and holds 250 ms after supply is stable.
// (RULE4) Reset pin is open drain, active low or active high by variant.
// (RULE5) SDA falling while SCL high restarts the watchdog count from zero.
// (RULE6) Enabled watchdog without restart within its period asserts reset.
// (RULE7) Host issues a start condition before every watchdog period expires.
// (RULE8) Two nonvolatile bits select the watchdog period and survive power cycles.
// (RULE9) Host may rewrite period bits, refused while protect pin and enable high.
// (RULE10) All control writes blocked while protect pin and protect enable are high.
// (RULE11) Reset from low supply or watchdog aborts the bus transaction in progress.
// (RULE12) While in reset, new bus transactions and nonvolatile writes are refused.
// (RULE13) A nonvolatile write already running when reset asserts completes normally.
// (RULE14) Start detector samples SDA and SCL always, addressed or not.
// (RULE15) Period codes: 00 1.4 s, 01 600 ms, 10 200 ms, 11 disabled.
// (RULE16) Watchdog and reset delays are oscillator counters cleared on loss of condition.
`timescale 1ns/1ps
`default_nettype none
`include "svr_defs.vh"

module svr_supervisor #(
    parameter                  RESET_ACTIVE_HIGH = 1'b0,
    parameter [`SVR_CNT_W-1:0] POR_CYC           = `SVR_POR_CYC,
    parameter [`SVR_CNT_W-1:0] BOR_CYC           = `SVR_BOR_CYC,
    parameter [`SVR_CNT_W-1:0] WDT_LONG_CYC      = `SVR_WDT_LONG_CYC,
    parameter [`SVR_CNT_W-1:0] WDT_MID_CYC       = `SVR_WDT_MID_CYC,
    parameter [`SVR_CNT_W-1:0] WDT_SHORT_CYC     = `SVR_WDT_SHORT_CYC,
    parameter [`SVR_CNT_W-1:0] NVWR_CYC          = `SVR_NVWR_CYC
) (
    input  wire       CLK_I,
    input  wire       RESET_N_I,
    input  wire       NV_CLR_N_I,
    input  wire       VCC_GOOD_I,
    input  wire       SDA_I,
    input  wire       SCL_I,
    input  wire       WP_I,
    input  wire       CTRL_WR_I,
    input  wire [7:0] CTRL_WDATA_I,
    output wire       CTRL_ACCEPT_O,
    output reg        CTRL_REFUSED_O,
    output reg  [7:0] CTRL_RDATA_O,
    output wire       NV_BUSY_O,
    output reg        BUS_ABORT_O,
    output reg        BUS_BLOCK_O,
    output reg        SYS_RESET_O,
    output wire       RST_O,
    output reg        RST_OE_N_O
);

    // Synchroniser order: {wp, scl, sda, vcc_good}
    wire [3:0] pins_async;
    reg  [3:0] sync_a;
    reg  [3:0] sync_b;
    // Reset levels in synchroniser order: bus lines rest high
    localparam [3:0] SYNC_IDLE = 4'h6;
    reg        sda_prev;
    wire       vcc_good;
    wire       sda;
    wire       scl;
    wire       wp;

    reg  [`SVR_CNT_W-1:0] rst_cnt;
    reg  [`SVR_CNT_W-1:0] wdt_cnt;
    reg                   por_pending;
    reg                   rst_active_q;
    reg  [`SVR_CNT_W-1:0] hold_lim;
    reg  [`SVR_CNT_W-1:0] wdt_lim;

    wire       rst_done;
    wire       rst_active;
    wire       start_det;
    wire       wdt_off;
    wire       wdt_timeout;
    wire       hw_protect;
    wire       wr_start;
    wire [2:0] nv_bits;
    wire       nv_busy;
    wire       prot_en;
    wire [1:0] period_sel;

    assign pins_async = {WP_I, SCL_I, SDA_I, VCC_GOOD_I};

    // Two flops per pin; the first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_sync
            always @(posedge CLK_I or negedge RESET_N_I) begin
                if (!RESET_N_I) begin
                    sync_a[g] <= SYNC_IDLE[g]; // Idle level, so release fakes no start
                    sync_b[g] <= SYNC_IDLE[g];
                end else begin
                    sync_a[g] <= pins_async[g];
                    sync_b[g] <= sync_a[g];
                end
            end
        end
    endgenerate

    assign vcc_good = sync_b[0];
    assign sda      = sync_b[1];
    assign scl      = sync_b[2];
    assign wp       = sync_b[3];

    // Previous SDA for edge detection; reset high so no false start at release
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sda_prev <= 1'b1;
        end else begin
            sda_prev <= sda;
        end
    end

    // Start condition seen on every cycle, no address gating
    assign start_det = sda_prev & ~sda & scl; // RULE5 RULE14

    // Nonvolatile control bits
    assign prot_en    = nv_bits[2];
    assign period_sel = nv_bits[1:0]; // RULE8

    // Period decode; disabled code holds the counter at zero
    always @* begin
        case (period_sel)
            `SVR_WDT_LONG:  wdt_lim = WDT_LONG_CYC; // RULE15
            `SVR_WDT_MID:   wdt_lim = WDT_MID_CYC;
            `SVR_WDT_SHORT: wdt_lim = WDT_SHORT_CYC;
            default:        wdt_lim = WDT_LONG_CYC;
        endcase
    end

    assign wdt_off = (period_sel == `SVR_WDT_OFF); // RULE15

    // First hold after power-on is longer than a brownout recovery
    always @* begin
        if (por_pending) begin
            hold_lim = POR_CYC; // RULE3
        end else begin
            hold_lim = BOR_CYC; // RULE2
        end
    end

    // Greater-or-equal because the limit shrinks once power-on is over
    assign rst_done   = (rst_cnt >= hold_lim);
    assign rst_active = ~vcc_good | ~rst_done; // RULE1 RULE3
    // A shorter period written mid-count must still bite at once
    assign wdt_timeout = ~rst_active & ~wdt_off & ~start_det
                         & (wdt_cnt >= wdt_lim - 1'b1); // RULE6

    // Reset hold counter: cleared by low supply or a watchdog bite
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_cnt     <= {`SVR_CNT_W{1'b0}};
            por_pending <= 1'b1;
        end else begin
            if (!vcc_good || wdt_timeout) begin
                rst_cnt <= {`SVR_CNT_W{1'b0}}; // RULE16 RULE6
            end else if (!rst_done) begin
                rst_cnt <= rst_cnt + 1'b1; // RULE2
            end
            if (vcc_good && rst_done) begin
                por_pending <= 1'b0;
            end
        end
    end

    // Watchdog counter: held at zero in reset or when disabled,
    // so a bite cannot repeat until the reset pulse has ended
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            wdt_cnt <= {`SVR_CNT_W{1'b0}};
        end else if (rst_active || wdt_off || start_det || wdt_timeout) begin
            wdt_cnt <= {`SVR_CNT_W{1'b0}}; // RULE5 RULE16
        end else begin
            wdt_cnt <= wdt_cnt + 1'b1; // RULE6
        end
    end

    // Control write gating: protect pin plus enable bit locks everything
    assign hw_protect    = wp & prot_en;
    assign wr_start      = CTRL_WR_I & ~hw_protect & ~rst_active & ~nv_busy; // RULE9 RULE10 RULE12
    assign CTRL_ACCEPT_O = wr_start;
    assign NV_BUSY_O     = nv_busy;

    svr_nvbits #(
        .NVWR_CYC   (NVWR_CYC)
    ) u_nvbits (
        .clk_i      (CLK_I),
        .nv_clr_n_i (NV_CLR_N_I),
        .wr_start_i (wr_start),
        .wdata_i    ({CTRL_WDATA_I[`SVR_BIT_PROT_EN],
                      CTRL_WDATA_I[`SVR_BIT_PERIOD_HI],
                      CTRL_WDATA_I[`SVR_BIT_PERIOD_LO]}),
        .bits_o     (nv_bits),
        .busy_o     (nv_busy) // RULE13
    );

    // Registered outputs; abort is a pulse on the rising edge of reset
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_active_q   <= 1'b1;
            BUS_ABORT_O    <= 1'b0;
            BUS_BLOCK_O    <= 1'b1;
            SYS_RESET_O    <= 1'b1;
            CTRL_REFUSED_O <= 1'b0;
            CTRL_RDATA_O   <= 8'h00;
            RST_OE_N_O     <= RESET_ACTIVE_HIGH ? 1'b1 : 1'b0;
        end else begin
            rst_active_q   <= rst_active;
            BUS_ABORT_O    <= rst_active & ~rst_active_q; // RULE11
            BUS_BLOCK_O    <= rst_active; // RULE12
            SYS_RESET_O    <= rst_active;
            CTRL_REFUSED_O <= CTRL_WR_I & ~wr_start; // RULE10
            CTRL_RDATA_O   <= {prot_en, period_sel, 5'h00};
            // Open drain: only ever pulls low, the pull-up makes the high
            if (RESET_ACTIVE_HIGH) begin
                RST_OE_N_O <= rst_active; // RULE4
            end else begin
                RST_OE_N_O <= ~rst_active; // RULE4
            end
        end
    end

    // Open-drain data is always low; the enable decides
    assign RST_O = 1'b0; // RULE4

endmodule // svr_supervisor

`default_nettype wire

// File: svr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module svr_sva #(
    parameter        RESET_ACTIVE_HIGH = 1'b0,
    parameter [26:0] WDT_LONG_CYC      = 27'd2000,
    parameter [26:0] WDT_MID_CYC       = 27'd1000,
    parameter [26:0] WDT_SHORT_CYC     = 27'd500
) (
    input wire logic       CLK_I,
    input wire logic       RESET_N_I,
    input wire logic       VCC_GOOD_I,
    input wire logic       SDA_I,
    input wire logic       SCL_I,
    input wire logic       WP_I,
    input wire logic       CTRL_WR_I,
    input wire logic       CTRL_ACCEPT_O,
    input wire logic       CTRL_REFUSED_O,
    input wire logic [7:0] CTRL_RDATA_O,
    input wire logic       NV_BUSY_O,
    input wire logic       BUS_ABORT_O,
    input wire logic       BUS_BLOCK_O,
    input wire logic       SYS_RESET_O,
    input wire logic       RST_O,
    input wire logic       RST_OE_N_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    logic [26:0] idle_cnt;
    logic        sda_q;
    logic [26:0] lim;
    // Limit from the committed code; slack covers the input synchronisers
    assign lim = CTRL_RDATA_O[6] ? WDT_SHORT_CYC : (CTRL_RDATA_O[5] ? WDT_MID_CYC : WDT_LONG_CYC);
    // Cycles without a start while the watchdog should be running
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            idle_cnt <= 27'h0;
            sda_q    <= 1'b1;
        end else begin
            sda_q    <= SDA_I;
            idle_cnt <= (SYS_RESET_O || (sda_q && !SDA_I && SCL_I) || (&CTRL_RDATA_O[6:5])) ?
                        27'h0 : idle_cnt + 27'h1;
        end
    end
    sequence s_busy;
        NV_BUSY_O [*8];
    endsequence
    sequence s_refused;
        ##1 CTRL_REFUSED_O;
    endsequence
    AST_VCC_LOW: assert property (!VCC_GOOD_I |-> ##[1:3] SYS_RESET_O)
        else $error("reset not raised on low supply");
    AST_BLOCK: assert property (BUS_BLOCK_O == SYS_RESET_O)
        else $error("bus block differs from reset");
    AST_PIN: assert property (!RST_O && (RST_OE_N_O == (SYS_RESET_O == RESET_ACTIVE_HIGH)))
        else $error("reset pin drive wrong");
    AST_ABORT: assert property (BUS_ABORT_O == $rose(SYS_RESET_O))
        else $error("abort pulse not tied to reset rise");
    AST_ACCEPT: assert property (CTRL_ACCEPT_O |-> (CTRL_WR_I && !NV_BUSY_O) ##1 !SYS_RESET_O)
        else $error("write accepted while busy or in reset");
    AST_NV_RUN: assert property (CTRL_ACCEPT_O |=> s_busy)
        else $error("nonvolatile write cut short");
    AST_REFUSE: assert property (CTRL_WR_I && !CTRL_ACCEPT_O |-> s_refused)
        else $error("refused write not flagged");
    AST_PROT: assert property (CTRL_WR_I && WP_I && $past(WP_I, 3) && CTRL_RDATA_O[7]
        && !$past(NV_BUSY_O) |-> !CTRL_ACCEPT_O)
        else $error("write accepted under protection");
    AST_WDT: assert property (idle_cnt <= lim + 27'd8)
        else $error("watchdog did not bite in time");
endmodule // svr_sva
bind svr_supervisor svr_sva #(.RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH), .WDT_LONG_CYC(WDT_LONG_CYC),
    .WDT_MID_CYC(WDT_MID_CYC), .WDT_SHORT_CYC(WDT_SHORT_CYC)) u_sva (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .VCC_GOOD_I(VCC_GOOD_I), .SDA_I(SDA_I), .SCL_I(SCL_I),
    .WP_I(WP_I), .CTRL_WR_I(CTRL_WR_I), .CTRL_ACCEPT_O(CTRL_ACCEPT_O),
    .CTRL_REFUSED_O(CTRL_REFUSED_O), .CTRL_RDATA_O(CTRL_RDATA_O), .NV_BUSY_O(NV_BUSY_O),
    .BUS_ABORT_O(BUS_ABORT_O), .BUS_BLOCK_O(BUS_BLOCK_O), .SYS_RESET_O(SYS_RESET_O),
    .RST_O(RST_O), .RST_OE_N_O(RST_OE_N_O));
`default_nettype wire

// File: svr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module svr_host_model (
    input  wire logic        en_i,
    input  wire logic [31:0] gap_i,
    output var  logic        sda_o,
    output var  logic        scl_o
);
    // Lines rest high on pull-ups; the bus clock moves only inside a frame
    initial begin
        sda_o = 1'b1;
        scl_o = 1'b1;
        forever begin
            #(gap_i);
            if (en_i) begin
                sda_o = 1'b0;
                #80;
                scl_o = 1'b0;
                #80;
                scl_o = 1'b1;
                #80;
                sda_o = 1'b1;
            end
        end
    end
endmodule // svr_host_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [26:0] POR = 27'd400;
    localparam logic [26:0] BOR = 27'd300;
    localparam logic [26:0] NVW = 27'd50;
    localparam logic [26:0] WDL = 27'd2000;
    localparam logic [26:0] WDM = 27'd1000;
    localparam logic [26:0] WDS = 27'd500;
    logic       clk = 1'b0, rst_n = 1'b0, nvclr_n = 1'b0, vcc = 1'b1, wp = 1'b0, wr = 1'b0;
    logic       host_en = 1'b1, accept, refused, busy, abort, block, sysrst, rst_o, oe_n;
    logic [7:0] wdata = 8'h00, rdata;
    logic [31:0] gap = 32'd2000;
    wire        sda, scl, pin;
    int         err_count = 0, checked = 0, cyc = 0, last_start = 0;
    assign pin = oe_n ? 1'b1 : rst_o; // Pull-up on the open-drain reset line
    svr_host_model i_host (.en_i(host_en), .gap_i(gap), .sda_o(sda), .scl_o(scl));
    svr_supervisor #(.POR_CYC(POR), .BOR_CYC(BOR), .WDT_LONG_CYC(WDL),
        .WDT_MID_CYC(WDM), .WDT_SHORT_CYC(WDS), .NVWR_CYC(NVW)) i_dut (
        .CLK_I(clk), .RESET_N_I(rst_n), .NV_CLR_N_I(nvclr_n), .VCC_GOOD_I(vcc), .SDA_I(sda),
        .SCL_I(scl), .WP_I(wp), .CTRL_WR_I(wr), .CTRL_WDATA_I(wdata), .CTRL_ACCEPT_O(accept),
        .CTRL_REFUSED_O(refused), .CTRL_RDATA_O(rdata), .NV_BUSY_O(busy), .BUS_ABORT_O(abort),
        .BUS_BLOCK_O(block), .SYS_RESET_O(sysrst), .RST_O(rst_o), .RST_OE_N_O(oe_n));
    always #10 clk = ~clk;
    // Cycle count doubles as the hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            end_sim();
        end
    end
    always @(negedge sda) if (scl === 1'b1) last_start = cyc;
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cw(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Control write; refusal shows one cycle later
    task automatic wr_ctrl(input logic [7:0] d, input logic acc);
        wdata = d;
        wr = 1'b1;
        #1 chk1(accept, acc);
        @(negedge clk);
        wr = 1'b0;
        chk1(refused, !acc);
    endtask
    task automatic t_power();
        cw(POR - 5);
        chk1(sysrst, 1'b1);
        chk1(pin, 1'b0);
        cw(10);
        chk1(sysrst, 1'b0);
        chk1(pin, 1'b1);
        $display("power-up test done");
    endtask
    task automatic t_brown();
        int n = 0;
        vcc = 1'b0;
        repeat (5) begin
            @(negedge clk);
            if (abort === 1'b1) n++;
        end
        chk1(n == 1, 1'b1);
        chk1(sysrst, 1'b1);
        chk1(block, 1'b1);
        vcc = 1'b1;
        cw(150);
        vcc = 1'b0;
        cw(5);
        vcc = 1'b1;
        cw(BOR - 10);
        chk1(sysrst, 1'b1);
        cw(20);
        chk1(sysrst, 1'b0);
        $display("brownout test done");
    endtask
    task automatic t_period();
        logic [7:0] codes [3] = '{8'h40, 8'h20, 8'h00};
        int         lims [3] = '{500, 1000, 2000};
        int         n;
        for (int i = 0; i < 3; i++) begin
            wr_ctrl(codes[i], 1'b1);
            cw(NVW + 3);
            chk8(rdata, codes[i]);
            // Starts spaced just inside the period must keep reset quiet
            gap = lims[i] * 20 - 1200;
            cw(lims[i] * 2);
            chk1(sysrst, 1'b0);
            gap = 32'd2000;
            host_en = 1'b0;
            n = 0;
            while (sysrst !== 1'b1 && n < 3000) begin
                @(negedge clk);
                n++;
            end
            n = cyc - last_start;
            chk1(n >= lims[i] && n <= lims[i] + 8, 1'b1);
            host_en = 1'b1;
            cw(BOR + 10);
            chk1(sysrst, 1'b0);
        end
        $display("period test done");
    endtask
    task automatic t_prot();
        wr_ctrl(8'he0, 1'b1);
        cw(NVW + 3);
        host_en = 1'b0;
        wp = 1'b1;
        cw(4);
        wr_ctrl(8'h00, 1'b0);
        cw(2600);
        chk8(rdata, 8'he0);
        chk1(sysrst, 1'b0);
        host_en = 1'b1;
        wp = 1'b0;
        cw(4);
        wr_ctrl(8'h00, 1'b1);
        cw(NVW + 3);
        chk8(rdata, 8'h00);
        $display("protect test done");
    endtask
    task automatic t_nvrst();
        wr_ctrl(8'h20, 1'b1);
        cw(2);
        vcc = 1'b0;
        cw(5);
        chk1(busy, 1'b1);
        cw(NVW);
        chk8(rdata, 8'h20);
        wr_ctrl(8'h40, 1'b0);
        vcc = 1'b1;
        cw(BOR + 10);
        chk1(sysrst, 1'b0);
        $display("write-through-reset test done");
    endtask
    // Mid-run power cycle: full hold again, nonvolatile bits kept; then factory clear
    task automatic t_cycle();
        rst_n = 1'b0;
        cw(3);
        chk1(sysrst, 1'b1);
        rst_n = 1'b1;
        t_power();
        chk8(rdata, 8'h20);
        nvclr_n = 1'b0;
        cw(1);
        nvclr_n = 1'b1;
        cw(2);
        chk8(rdata, 8'h00);
        $display("power-cycle test done");
    endtask
    initial begin
        cw(3);
        rst_n = 1'b1;
        nvclr_n = 1'b1;
        t_power();
        t_brown();
        t_period();
        t_prot();
        t_nvrst();
        t_cycle();
        end_sim();
    end
endmodule // testbench
`default_nettype wire
